// [inc/xdl_pkg.sv]
/*
  xdl_pkg: shared constants and carrier types for the exclusive-OR and
  direction-load execution block.
  assumes: included before any design file that imports it.
*/
`default_nettype none
package xdl_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_PORT_A = 3'h5;
  localparam logic [SEL_W-1:0] SEL_PORT_B = 3'h6;
  localparam logic [SEL_W-1:0] SEL_PORT_C = 3'h7;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_MEM = 1'b1;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_XOR_IMMEDIATE,
    OP_XOR_MEMORY,
    OP_DIRECTION_LOAD
  } xdl_op_type;

  // one decoded instruction from the decoder
  typedef struct packed {
    xdl_op_type op;
    logic [DATA_W-1:0] literal;
    logic [ADDR_W-1:0] addr;
    logic dest;
    logic [SEL_W-1:0] sel;
  } xdl_instr_type;

  // one data-memory write-back
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } xdl_mem_wr_type;
endpackage
`default_nettype wire

// [logic/xdl_dir_reg.sv]
/*
  xdl_dir_reg: one port direction register, loaded from the working register.
  assumes: synchronous reset copy from the top module.
*/
`timescale 1ns/100ps
`default_nettype none
module xdl_dir_reg
  import xdl_pkg::*;
#(
  parameter logic [DATA_W-1:0] RESET_VAL = DIR_RESET
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // load
  input wire logic load_i,
  input wire logic [DATA_W-1:0] data_i,
  // value
  output logic [DATA_W-1:0] value_o
);
  logic [DATA_W-1:0] value_d;
  logic [DATA_W-1:0] value_q;

  always_comb begin
    value_d = value_q;
    if (load_i) begin
      value_d = data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;
endmodule
`default_nettype wire

// [logic/xdl_exec.sv]
/*
  xdl_exec: executes the literal and memory exclusive-OR instructions and
  the direction-load instruction, holding the working register, zero flag
  and the three port direction registers.
  assumes: the decoder presents one instruction per cycle with instr_valid_i;
  for the memory exclusive-OR the data path supplies the addressed byte on
  mem_rdata_i in the same cycle; carry and digit-carry live outside.
*/
`timescale 1ns/100ps
`default_nettype none
module xdl_exec
  import xdl_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // decoded instruction
  input wire logic instr_valid_i,
  input wire xdl_instr_type instr_i,
  // data memory read data for the addressed location
  input wire logic [DATA_W-1:0] mem_rdata_i,
  // data memory write-back
  output xdl_mem_wr_type mem_wr_o,
  // core state
  output logic [DATA_W-1:0] w_o,
  output logic zero_o,
  output logic illegal_o,
  // port direction registers
  output logic [DATA_W-1:0] port_a_direction_o,
  output logic [DATA_W-1:0] port_b_direction_o,
  output logic [DATA_W-1:0] port_c_direction_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;

  logic do_xor_imm;
  logic do_xor_mem;
  logic do_dir_load;
  logic [DATA_W-1:0] xor_operand;
  logic [DATA_W-1:0] result;
  logic result_to_w;
  logic result_to_mem;
  logic sel_legal;
  logic load_a;
  logic load_b;
  logic load_c;
  logic [DATA_W-1:0] w_d;
  logic [DATA_W-1:0] w_q;
  logic zero_d;
  logic zero_q;
  logic illegal_d;
  logic illegal_q;
  xdl_mem_wr_type mem_wr_d;
  xdl_mem_wr_type mem_wr_q;

  // reset release through two flip-flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= RST_SYNC_INIT;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // instruction decode
  always_comb begin
    do_xor_imm = 1'b0;
    do_xor_mem = 1'b0;
    do_dir_load = 1'b0;
    if (instr_valid_i) begin
      unique case (instr_i.op)
        OP_XOR_IMMEDIATE: begin
          do_xor_imm = 1'b1;
        end
        OP_XOR_MEMORY: begin
          do_xor_mem = 1'b1;
        end
        OP_DIRECTION_LOAD: begin
          do_dir_load = 1'b1;
        end
        OP_NONE: begin
          do_dir_load = 1'b0;
        end
      endcase
    end
  end

  // one exclusive-OR serves both instructions; w is always one operand
  always_comb begin
    xor_operand = instr_i.literal;
    if (do_xor_mem) begin
      xor_operand = mem_rdata_i;
    end
    result = w_q ^ xor_operand;
    result_to_w = do_xor_imm || (do_xor_mem && (instr_i.dest == DEST_W));
    result_to_mem = do_xor_mem && (instr_i.dest == DEST_MEM);
  end

  // only 5, 6 and 7 name a direction register
  always_comb begin
    load_a = 1'b0;
    load_b = 1'b0;
    load_c = 1'b0;
    sel_legal = 1'b1;
    unique case (instr_i.sel)
      SEL_PORT_A: begin
        load_a = do_dir_load;
      end
      SEL_PORT_B: begin
        load_b = do_dir_load;
      end
      SEL_PORT_C: begin
        load_c = do_dir_load;
      end
      default: begin
        sel_legal = 1'b0;
      end
    endcase
  end

  // working register: written by a xor whose destination is w
  always_comb begin
    w_d = w_q;
    if (result_to_w) begin
      w_d = result;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= W_RESET;
    end else begin
      w_q <= w_d;
    end
  end

  // zero flag: both xors update it, the direction load never does
  always_comb begin
    zero_d = zero_q;
    if (do_xor_imm || do_xor_mem) begin
      zero_d = (result == '0);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= zero_d;
    end
  end

  // data memory write-back: a one-cycle pulse after the instruction
  always_comb begin
    mem_wr_d = '0;
    if (result_to_mem) begin
      mem_wr_d.we = 1'b1;
      mem_wr_d.addr = instr_i.addr;
      mem_wr_d.data = result;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_q <= '0;
    end else begin
      mem_wr_q <= mem_wr_d;
    end
  end

  // refused direction operand: a one-cycle pulse and nothing loaded
  always_comb begin
    illegal_d = do_dir_load && !sel_legal;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal_d;
    end
  end

  xdl_dir_reg #(.RESET_VAL(DIR_RESET)) u_dir_a (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .load_i(load_a),
    .data_i(w_q),
    .value_o(port_a_direction_o)
  );

  xdl_dir_reg #(.RESET_VAL(DIR_RESET)) u_dir_b (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .load_i(load_b),
    .data_i(w_q),
    .value_o(port_b_direction_o)
  );

  xdl_dir_reg #(.RESET_VAL(DIR_RESET)) u_dir_c (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .load_i(load_c),
    .data_i(w_q),
    .value_o(port_c_direction_o)
  );

  assign w_o = w_q;
  assign zero_o = zero_q;
  assign illegal_o = illegal_q;
  assign mem_wr_o = mem_wr_q;
endmodule
`default_nettype wire

// [testbench/xdl_exec_props.sv]
/* xdl_exec_props: port assertions for the execution block.
  assumes: bound to xdl_exec; xdl_pkg compiled first. */
`timescale 1ns/100ps
`default_nettype none
module xdl_exec_props
  import xdl_pkg::*;
(
  // watched ports
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire xdl_instr_type instr_i,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire xdl_mem_wr_type mem_wr_o,
  input wire logic [DATA_W-1:0] w_o,
  input wire logic zero_o,
  input wire logic illegal_o,
  input wire logic [DATA_W-1:0] port_a_direction_o,
  input wire logic [DATA_W-1:0] port_b_direction_o,
  input wire logic [DATA_W-1:0] port_c_direction_o
);
  wire imm = instr_valid_i && instr_i.op == OP_XOR_IMMEDIATE;
  wire mem = instr_valid_i && instr_i.op == OP_XOR_MEMORY;
  wire dir = instr_valid_i && instr_i.op == OP_DIRECTION_LOAD;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  AST_IMM_W: assert property (imm |=> w_o == ($past(w_o) ^ $past(instr_i.literal)))
    else $error("literal xor result wrong");
  AST_IMM_Z: assert property (imm |=>
    zero_o == (($past(w_o) ^ $past(instr_i.literal)) == 8'h00))
    else $error("literal xor zero flag wrong");
  AST_MEM_W: assert property (mem && !instr_i.dest |=> !mem_wr_o.we
    && w_o == ($past(w_o) ^ $past(mem_rdata_i)))
    else $error("memory xor to w wrong");
  AST_MEM_WB: assert property (mem && instr_i.dest |=> mem_wr_o.we && $stable(w_o)
    && mem_wr_o.addr == $past(instr_i.addr)
    && mem_wr_o.data == ($past(w_o) ^ $past(mem_rdata_i)))
    else $error("memory write-back wrong");
  AST_MEM_Z: assert property (mem |=>
    zero_o == (($past(w_o) ^ $past(mem_rdata_i)) == 8'h00))
    else $error("memory xor zero flag wrong");
  AST_DIR_OK: assert property (dir && instr_i.sel >= SEL_PORT_A |=> !illegal_o
    && $stable(zero_o) && $stable(w_o) && !mem_wr_o.we)
    else $error("direction load touched flags");
  AST_IDLE: assert property (!imm && !mem && !dir |=> $stable(w_o) && $stable(zero_o)
    && !mem_wr_o.we && !illegal_o)
    else $error("idle cycle changed state");
  AST_DIR_A: assert property (dir && instr_i.sel == SEL_PORT_A |=> port_a_direction_o == $past(w_o))
    else $error("port a direction load wrong");
  AST_DIR_B: assert property (dir && instr_i.sel == SEL_PORT_B |=> port_b_direction_o == $past(w_o))
    else $error("port b direction load wrong");
  AST_DIR_C: assert property (dir && instr_i.sel == SEL_PORT_C |=> port_c_direction_o == $past(w_o))
    else $error("port c direction load wrong");
  AST_DIR_BAD: assert property (dir && instr_i.sel < SEL_PORT_A |=> illegal_o && $stable(zero_o)
    && $stable(port_a_direction_o) && $stable(port_b_direction_o) && $stable(port_c_direction_o))
    else $error("bad direction operand not refused");
endmodule
bind xdl_exec xdl_exec_props u_xdl_exec_props (.clock_i, .arst_n_i, .instr_valid_i, .instr_i,
  .mem_rdata_i, .mem_wr_o, .w_o, .zero_o, .illegal_o, .port_a_direction_o,
  .port_b_direction_o, .port_c_direction_o);
`default_nettype wire

// [testbench/xdl_exec_test.sv]
/* xdl_exec_test: directed bench for the execution block.
  assumes: xdl_pkg, xdl_exec and the checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module xdl_exec_test
  import xdl_pkg::*;
;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  xdl_instr_type instr_i = '0;
  logic [DATA_W-1:0] mem_rdata_i = 8'h00;
  xdl_mem_wr_type mem_wr_o;
  logic [DATA_W-1:0] w_o, port_a_direction_o, port_b_direction_o, port_c_direction_o;
  logic zero_o, illegal_o;
  int bad_count = 0;
  int comparisons = 0;
  logic [DATA_W-1:0] w_e;
  wire [23:0] dirs = {port_c_direction_o, port_b_direction_o, port_a_direction_o};
  xdl_exec u_xdl_exec (.clock_i, .arst_n_i, .instr_valid_i, .instr_i, .mem_rdata_i, .mem_wr_o,
    .w_o, .zero_o, .illegal_o, .port_a_direction_o, .port_b_direction_o, .port_c_direction_o);
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic issue(input xdl_op_type op, input logic [7:0] k, input logic [6:0] a,
    input logic d, input logic [2:0] s, input logic [7:0] rd);
    @(negedge clock_i);
    instr_valid_i = 1'b1;
    instr_i = '{op, k, a, d, s};
    mem_rdata_i = rd;
    @(negedge clock_i);
    instr_valid_i = 1'b0;
  endtask
  task automatic t_imm;
    check("dirs", dirs[7:0], DIR_RESET);
    issue(OP_XOR_IMMEDIATE, 8'hA5, 7'h00, 1'b0, 3'h0, 8'h00);
    check("w", w_o, 8'hA5);
    check("zero", {7'h00, zero_o}, 8'h00);
    issue(OP_XOR_IMMEDIATE, 8'hA5, 7'h00, 1'b0, 3'h0, 8'h00);
    check("zero", {7'h00, zero_o}, 8'h01);
  endtask
  task automatic t_mem;
    issue(OP_XOR_IMMEDIATE, 8'h3C, 7'h00, 1'b0, 3'h0, 8'h00);
    issue(OP_XOR_MEMORY, 8'h00, 7'h7F, DEST_MEM, 3'h0, 8'h3C);
    check("we", {7'h00, mem_wr_o.we}, 8'h01);
    check("addr", {1'b0, mem_wr_o.addr}, 8'h7F);
    check("w", w_o, 8'h3C);
    check("zero", {7'h00, zero_o}, 8'h01);
    issue(OP_XOR_MEMORY, 8'h00, 7'h00, DEST_W, 3'h0, 8'hFF);
    check("w", w_o, 8'hC3);
    check("we", {7'h00, mem_wr_o.we}, 8'h00);
    check("zero", {7'h00, zero_o}, 8'h00);
    issue(OP_XOR_MEMORY, 8'h00, 7'h2A, DEST_MEM, 3'h0, 8'h0F);
    check("data", mem_wr_o.data, 8'hCC);
    check("addr", {1'b0, mem_wr_o.addr}, 8'h2A);
    check("w", w_o, 8'hC3);
  endtask
  task automatic t_dir;
    w_e = 8'hC3;
    for (int i = 0; i < 3; i++) begin
      w_e = w_e ^ 8'h11;
      issue(OP_XOR_IMMEDIATE, 8'h11, 7'h00, 1'b0, 3'h0, 8'h00);
      issue(OP_DIRECTION_LOAD, 8'h00, 7'h00, 1'b0, SEL_PORT_A + 3'(i), 8'h00);
      check("dir", dirs[i*8+:8], w_e);
    end
    issue(OP_XOR_IMMEDIATE, 8'hFF, 7'h00, 1'b0, 3'h0, 8'h00);
    issue(OP_DIRECTION_LOAD, 8'h00, 7'h00, 1'b0, 3'h4, 8'h00);
    check("illegal", {7'h00, illegal_o}, 8'h01);
    check("dir", dirs[23:16], w_e);
    check("dir", dirs[7:0], w_e);
    @(negedge clock_i);
    check("illegal", {7'h00, illegal_o}, 8'h00);
  endtask
  task automatic t_reset;
    @(negedge clock_i);
    arst_n_i = 1'b0;
    #1;
    check("w", w_o, W_RESET);
    check("dir", dirs[15:8], DIR_RESET);
    check("dir", dirs[23:16], DIR_RESET);
    check("zero", {7'h00, zero_o}, 8'h00);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    issue(OP_XOR_IMMEDIATE, 8'h5A, 7'h00, 1'b0, 3'h0, 8'h00);
    check("w", w_o, 8'h5A);
  endtask
  task automatic close_out;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
  initial begin
    repeat (4) @(negedge clock_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    t_imm;
    t_mem;
    t_dir;
    t_reset;
    close_out;
  end
endmodule
`default_nettype wire
